/* File: pkg/sync_mode_pkg.sv */
// Notes on behaviour
// - degraded reference enters holdover before switching
// - recovery within guard returns normal, same reference
// - guard expiry with primary bad allows secondary
// - short primary loss: normal to holdover only
// - long loss goes secondary only if secondary good
// - primary loss cleared returns to primary normal
// - manual: mode pins pick normal, holdover, freerun
// - manual: reference pin picks primary or secondary
// - manual: guard pin enables correction on holdover exit to normal while on primary
// - clear pin realigns output phase to input
// - reset returns every state machine to start
// - correction off: realign on every holdover exit to normal
// - automatic short holdovers never apply correction
// - holdover value captured in locked normal only
package sync_mode_pkg;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_HOLD = 8'h08;
  localparam int CTRL_REALIGN_BIT = 0;
  // mode select pin codes {hi,lo}
  localparam logic [1:0] SEL_NORMAL = 2'h0;
  localparam logic [1:0] SEL_HOLD = 2'h1;
  localparam logic [1:0] SEL_FREE = 2'h2;
  localparam logic [1:0] SEL_AUTO = 2'h3;
  // mode output codes
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_HOLD = 2'h1;
  localparam logic [1:0] MODE_FREE = 2'h2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // synchronised pin vector positions
  localparam int PIN_LOSS1 = 0;
  localparam int PIN_LOSS2 = 1;
  localparam int PIN_MS_LO = 2;
  localparam int PIN_MS_HI = 3;
  localparam int PIN_REFERENCE_CHOOSE = 4;
  localparam int PIN_GUARD = 5;
  localparam int PIN_CLR = 6;
  localparam int PIN_N = 7;
  localparam int RST_MIN_NS = 300;
  localparam int CLK_NS = 8;
  localparam int RST_MIN_CYC = (RST_MIN_NS + CLK_NS - 1) / CLK_NS;
  typedef enum logic [2:0] {ST_PRI_NORM, ST_PRI_HOLD, ST_SEC_NORM, ST_SEC_HOLD, ST_MANUAL} st_e;
endpackage

/* File: rtl/sync_mode_ctrl.sv */
// Implementation choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
module sync_mode_ctrl #(
  parameter int FREQ_W = 32,
  parameter int AW = 8
)(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic primary_loss_in_i,
  input wire logic secondary_loss_in_i,
  input wire logic mode_select_lo_i,
  input wire logic mode_select_hi_i,
  input wire logic reference_choose_i,
  input wire logic guard_time_in_i,
  input wire logic phase_offset_clear_i,
  input wire logic locked_i,
  input wire logic [FREQ_W-1:0] freq_word_i,
  output logic [1:0] mode_o,
  output logic ref_secondary_o,
  output logic realign_o,
  output logic tie_apply_o,
  output logic [FREQ_W-1:0] holdover_freq_o,
  input wire logic [AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

////////////////////////////////////////////////////////////////////////////////
// pin synchronisers: value moves only once stages two and three agree

  localparam int N = sync_mode_pkg::PIN_N;
  logic [N-1:0] pins_raw;
  logic [N-1:0] s1_r;
  logic [N-1:0] s2_r;
  logic [N-1:0] s3_r;
  logic [N-1:0] filt_r;
  logic [N-1:0] filt_d_r;

  assign pins_raw = {phase_offset_clear_i, guard_time_in_i, reference_choose_i,
                     mode_select_hi_i, mode_select_lo_i, secondary_loss_in_i,
                     primary_loss_in_i};

  genvar gi;
  generate
    for (gi = 0; gi < N; gi++)
    begin : g_sync
      always_ff @(posedge clk_i)
      begin
        if (!rstn_i)
        begin
          s1_r[gi] <= 1'b0;
          s2_r[gi] <= 1'b0;
          s3_r[gi] <= 1'b0;
          filt_r[gi] <= 1'b0;
          filt_d_r[gi] <= 1'b0;
        end
        else
        begin
          s1_r[gi] <= pins_raw[gi];
          s2_r[gi] <= s1_r[gi];
          s3_r[gi] <= s2_r[gi];
          if (s2_r[gi] == s3_r[gi])
            filt_r[gi] <= s3_r[gi];
          filt_d_r[gi] <= filt_r[gi];
        end
      end
    end
  endgenerate

  wire loss1 = filt_r[sync_mode_pkg::PIN_LOSS1];
  wire loss2 = filt_r[sync_mode_pkg::PIN_LOSS2];
  wire guard = filt_r[sync_mode_pkg::PIN_GUARD];
  wire reference_choose = filt_r[sync_mode_pkg::PIN_REFERENCE_CHOOSE];
  wire [1:0] msel = {filt_r[sync_mode_pkg::PIN_MS_HI], filt_r[sync_mode_pkg::PIN_MS_LO]};
  wire auto_mode = (msel == sync_mode_pkg::SEL_AUTO);
  // guard expiry is its low-to-high edge
  wire guard_rise = guard && !filt_d_r[sync_mode_pkg::PIN_GUARD];
  wire clr_rise = filt_r[sync_mode_pkg::PIN_CLR] && !filt_d_r[sync_mode_pkg::PIN_CLR];

////////////////////////////////////////////////////////////////////////////////
// automatic state machine

  sync_mode_pkg::st_e st_r;
  sync_mode_pkg::st_e st_nxt;
  logic expired_r;
  logic expired_nxt;

  always_comb
  begin
    st_nxt = st_r;
    expired_nxt = expired_r;
    case (st_r)
      sync_mode_pkg::ST_PRI_NORM:
        if (loss1)
          st_nxt = sync_mode_pkg::ST_PRI_HOLD;
      sync_mode_pkg::ST_PRI_HOLD:
        if (!loss1)
          st_nxt = sync_mode_pkg::ST_PRI_NORM;
        else if ((guard_rise || expired_r) && !loss2)
          st_nxt = sync_mode_pkg::ST_SEC_NORM;
        else if (guard_rise)
          expired_nxt = 1'b1;
      sync_mode_pkg::ST_SEC_NORM:
        if (!loss1)
          st_nxt = sync_mode_pkg::ST_PRI_NORM;
        else if (loss2)
          st_nxt = sync_mode_pkg::ST_SEC_HOLD;
      sync_mode_pkg::ST_SEC_HOLD:
        if (!loss1)
          st_nxt = sync_mode_pkg::ST_PRI_NORM;
        else if (!loss2)
          st_nxt = sync_mode_pkg::ST_SEC_NORM;
      sync_mode_pkg::ST_MANUAL:
        st_nxt = sync_mode_pkg::ST_PRI_NORM;
      default:
        st_nxt = sync_mode_pkg::ST_PRI_NORM;
    endcase
    if (st_nxt != sync_mode_pkg::ST_PRI_HOLD)
      expired_nxt = 1'b0;
    if (!auto_mode)
      st_nxt = sync_mode_pkg::ST_MANUAL;
  end

////////////////////////////////////////////////////////////////////////////////
// mode, reference and phase control

  wire [1:0] auto_mode_val = (st_nxt == sync_mode_pkg::ST_PRI_HOLD ||
                              st_nxt == sync_mode_pkg::ST_SEC_HOLD) ?
                             sync_mode_pkg::MODE_HOLD : sync_mode_pkg::MODE_NORMAL;
  wire auto_ref_val = (st_nxt == sync_mode_pkg::ST_SEC_NORM ||
                       st_nxt == sync_mode_pkg::ST_SEC_HOLD);
  // manual encoding maps pin code straight onto mode code
  wire [1:0] mode_nxt = auto_mode ? auto_mode_val : msel;
  wire ref_nxt = auto_mode ? auto_ref_val : reference_choose;
  wire hold_to_norm = (mode_o == sync_mode_pkg::MODE_HOLD) &&
                      (mode_nxt == sync_mode_pkg::MODE_NORMAL);
  // correction only for primary holdover exit, and never in auto
  wire tie_en = !auto_mode && guard && !ref_nxt && !ref_secondary_o;
  wire soft_realign;
  wire tie_apply_nxt = hold_to_norm && tie_en;
  // without correction every holdover exit to normal realigns, so offset never piles up
  wire realign_nxt = (hold_to_norm && !tie_en) || clr_rise || soft_realign;

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      st_r <= sync_mode_pkg::ST_PRI_NORM;
      expired_r <= 1'b0;
      mode_o <= sync_mode_pkg::MODE_NORMAL;
      ref_secondary_o <= 1'b0;
      realign_o <= 1'b0;
      tie_apply_o <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
      expired_r <= expired_nxt;
      mode_o <= mode_nxt;
      ref_secondary_o <= ref_nxt;
      realign_o <= realign_nxt;
      tie_apply_o <= tie_apply_nxt;
    end
  end

  // stored value only tracks while locked in normal; frozen otherwise
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
      holdover_freq_o <= '0;
    else if (mode_o == sync_mode_pkg::MODE_NORMAL && locked_i)
      holdover_freq_o <= freq_word_i;
  end

////////////////////////////////////////////////////////////////////////////////
// axi4-lite slave, one write and one read at a time

  logic aw_got_r;
  logic w_got_r;
  logic [AW-1:0] awaddr_r;
  logic [31:0] wdata_r;
  logic wstrb0_r;
  logic realign_req_r;

  assign s_axi_awready = !aw_got_r && !s_axi_bvalid;
  assign s_axi_wready = !w_got_r && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  wire do_write = aw_got_r && w_got_r && !s_axi_bvalid;
  wire wr_ctrl = awaddr_r == AW'(sync_mode_pkg::OFS_CTRL);
  assign soft_realign = realign_req_r;
  wire rd_ctrl = s_axi_araddr == AW'(sync_mode_pkg::OFS_CTRL);
  wire rd_stat = s_axi_araddr == AW'(sync_mode_pkg::OFS_STATUS);
  wire rd_hold = s_axi_araddr == AW'(sync_mode_pkg::OFS_HOLD);
  wire [31:0] status_word = {25'h0, locked_i, tie_en, auto_mode, ref_secondary_o,
                             mode_o == sync_mode_pkg::MODE_HOLD, mode_o};
  wire [31:0] rd_mux = rd_stat ? status_word : (rd_hold ? 32'(holdover_freq_o) : 32'h0);

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= 32'h0;
      wstrb0_r <= 1'b0;
      realign_req_r <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= sync_mode_pkg::RESP_OKAY;
    end
    else
    begin
      realign_req_r <= do_write && wr_ctrl && wstrb0_r &&
                       wdata_r[sync_mode_pkg::CTRL_REALIGN_BIT];
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_got_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_got_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb0_r <= s_axi_wstrb[0];
      end
      if (do_write)
      begin
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ctrl ? sync_mode_pkg::RESP_OKAY : sync_mode_pkg::RESP_SLVERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= sync_mode_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= (rd_ctrl || rd_stat || rd_hold) ?
                     sync_mode_pkg::RESP_OKAY : sync_mode_pkg::RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

////////////////////////////////////////////////////////////////////////////////
// checks

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  sequence s_pri_loss;
    auto_mode && st_r == sync_mode_pkg::ST_PRI_NORM && loss1;
  endsequence
  sequence s_leave_hold;
    mode_o == sync_mode_pkg::MODE_HOLD ##1 mode_o == sync_mode_pkg::MODE_NORMAL;
  endsequence

  AST_LOSS_TO_HOLD: assert property (s_pri_loss |=>
    mode_o == sync_mode_pkg::MODE_HOLD && !ref_secondary_o) else $error("no holdover on loss");
  AST_HOLD_FIRST: assert property (auto_mode && $past(auto_mode) && $rose(ref_secondary_o) |->
    $past(mode_o) == sync_mode_pkg::MODE_HOLD) else $error("switch without holdover");
  AST_RECOVER_SAME: assert property (auto_mode && st_r == sync_mode_pkg::ST_PRI_HOLD && !loss1 |=>
    mode_o == sync_mode_pkg::MODE_NORMAL && !ref_secondary_o) else $error("bad recovery");
  AST_GUARD_SWITCH: assert property (auto_mode && st_r == sync_mode_pkg::ST_PRI_HOLD && loss1 &&
    guard_rise && !loss2 |=> ref_secondary_o && mode_o == sync_mode_pkg::MODE_NORMAL)
    else $error("no switch at guard expiry");
  AST_SEC_BAD: assert property (auto_mode && st_r == sync_mode_pkg::ST_PRI_HOLD && loss2 |=>
    !ref_secondary_o) else $error("switched to bad secondary");
  AST_BACK_PRI: assert property (auto_mode && st_r == sync_mode_pkg::ST_SEC_NORM && !loss1 |=>
    st_r == sync_mode_pkg::ST_PRI_NORM && !ref_secondary_o) else $error("no return to primary");
  AST_MANUAL_SEL: assert property (!auto_mode |=> mode_o == $past(msel) &&
    ref_secondary_o == $past(reference_choose)) else $error("manual select ignored");
  AST_CLR_REALIGN: assert property (clr_rise |=> realign_o) else $error("clear ignored");
  AST_EXIT_REALIGN: assert property (s_leave_hold |-> realign_o || tie_apply_o)
    else $error("holdover exit without realign");
  AST_AUTO_NO_TIE: assert property (auto_mode ##1 auto_mode |-> !tie_apply_o)
    else $error("correction in auto");
  AST_HOLD_FROZEN: assert property (mode_o != sync_mode_pkg::MODE_NORMAL |=>
    $stable(holdover_freq_o)) else $error("holdover value moved");
  AST_RESET_STATE: assert property (disable iff (1'b0) !rstn_i |=>
    st_r == sync_mode_pkg::ST_PRI_NORM && mode_o == sync_mode_pkg::MODE_NORMAL && !realign_o)
    else $error("reset state wrong");
endmodule

/* File: verification/far_end_model.sv */
`timescale 1ns/1ps
module far_end_model (
  input wire logic clk_i,
  output logic p_loss_o,
  output logic s_loss_o,
  output logic ms_lo_o,
  output logic ms_hi_o,
  output logic ref_pick_o,
  output logic guard_o,
  output logic clr_o,
  output logic locked_o,
  output logic [31:0] freq_o
);
  initial
  begin
    {p_loss_o, s_loss_o, ms_lo_o, ms_hi_o, ref_pick_o, guard_o, clr_o, locked_o} = 8'h00;
    freq_o = 32'h0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // pins move just after an edge, like a registered controller
  task automatic pins(input logic l1, input logic l2, input logic [1:0] code,
                      input logic rp, input logic g, input logic c);
    @(posedge clk_i);
    p_loss_o <= l1;
    s_loss_o <= l2;
    {ms_hi_o, ms_lo_o} <= code;
    ref_pick_o <= rp;
    // guard stays low over short holdovers unless correction is wanted
    guard_o <= g;
    clr_o <= c;
  endtask
  task automatic loop(input logic lk, input logic [31:0] f);
    @(posedge clk_i);
    locked_o <= lk;
    freq_o <= f;
  endtask
endmodule

/* File: verification/tb_sync_reference_mode_control.sv */
`timescale 1ns/1ps
module tb_sync_reference_mode_control;
  logic clk_i, rstn_i, p_loss, s_loss, ms_lo, ms_hi, ref_pick, guard, clr, locked;
  logic [31:0] freq, holdover_freq_o, wdata, rdata, f1, f2;
  logic [1:0] mode_o, bresp, rresp;
  logic ref_secondary_o, realign_o, tie_apply_o;
  logic [7:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [3:0] wstrb;
  logic [33:0] rq[$], bq[$], pq[$];
  int miscompares, n_tests;
  far_end_model u_far (.clk_i(clk_i), .p_loss_o(p_loss), .s_loss_o(s_loss), .ms_lo_o(ms_lo),
    .ms_hi_o(ms_hi), .ref_pick_o(ref_pick), .guard_o(guard), .clr_o(clr), .locked_o(locked),
    .freq_o(freq));
  sync_mode_ctrl u_dut (.clk_i(clk_i), .rstn_i(rstn_i), .primary_loss_in_i(p_loss),
    .secondary_loss_in_i(s_loss), .mode_select_lo_i(ms_lo), .mode_select_hi_i(ms_hi),
    .reference_choose_i(ref_pick), .guard_time_in_i(guard), .phase_offset_clear_i(clr),
    .locked_i(locked), .freq_word_i(freq), .mode_o(mode_o), .ref_secondary_o(ref_secondary_o),
    .realign_o(realign_o), .tie_apply_o(tie_apply_o), .holdover_freq_o(holdover_freq_o),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  initial
  begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] g);
    n_tests++;
    if (g !== e)
    begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wrap_up;
    miscompares += rq.size() + bq.size() + pq.size();
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic settle;
    repeat (8) @(posedge clk_i);
  endtask
  task automatic lvl(input logic [1:0] m, input logic r);
    chk("mode", {32'h0, m}, {32'h0, mode_o});
    chk("ref", {33'h0, r}, {33'h0, ref_secondary_o});
  endtask
  // write address and data offered together, each dropped once taken
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                     input logic [1:0] er);
    bq.push_back({32'h0, er});
    @(posedge clk_i);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clk_i);
      awvalid <= awvalid && (awready !== 1'b1);
      wvalid <= wvalid && (wready !== 1'b1);
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask
  task automatic axr(input logic [7:0] a, input logic [1:0] er, input logic [31:0] ed);
    rq.push_back({er, ed});
    @(posedge clk_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clk_i);
      arvalid <= arvalid && (arready !== 1'b1);
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // results are matched in order against the notes left by the drivers
  always @(posedge clk_i)
  begin
    if (rvalid === 1'b1 && rready === 1'b1)
      chk("rdata", rq.size() ? rq.pop_front() : '1, {rresp, rdata});
    if (bvalid === 1'b1 && bready === 1'b1)
      chk("bresp", bq.size() ? bq.pop_front() : '1, {32'h0, bresp});
    // outputs are unknown until the first reset edge
    if (rstn_i === 1'b1 && (realign_o === 1'b1 || tie_apply_o !== 1'b0))
      chk("pulse", pq.size() ? pq.pop_front() : '1, {32'h0, tie_apply_o, realign_o});
  end
  initial
  begin
    repeat (6000) @(posedge clk_i);
    miscompares++;
    wrap_up;
  end
  initial
  begin
    rstn_i = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'h0;
    miscompares = 0;
    n_tests = 0;
    void'($urandom(32'h8f0c4ac7));
    f1 = $urandom();
    f2 = ~f1;
    repeat (16) @(posedge clk_i);
    rstn_i <= 1'b1;
    settle;
    lvl(sync_mode_pkg::MODE_NORMAL, 1'b0);
    u_far.loop(1'b1, f1);
    settle;
    chk("hold_freq", {2'h0, f1}, {2'h0, holdover_freq_o});
    axr(sync_mode_pkg::OFS_STATUS, sync_mode_pkg::RESP_OKAY, 32'h40);
    axr(sync_mode_pkg::OFS_HOLD, sync_mode_pkg::RESP_OKAY, f1);
    pq.push_back(34'h1);
    axw(sync_mode_pkg::OFS_CTRL, 32'h1, 4'($urandom()) | 4'h1, sync_mode_pkg::RESP_OKAY);
    // lane 0 masked: the realign bit must be ignored
    axw(sync_mode_pkg::OFS_CTRL, $urandom() | 32'h1, 4'($urandom()) & 4'he,
        sync_mode_pkg::RESP_OKAY);
    axw(8'h0c, $urandom(), 4'($urandom()), sync_mode_pkg::RESP_SLVERR);
    axr(8'h10, sync_mode_pkg::RESP_SLVERR, 32'h0);
    axr(sync_mode_pkg::OFS_CTRL, sync_mode_pkg::RESP_OKAY, 32'h0);
    pq.push_back(34'h1);
    u_far.pins(0, 0, sync_mode_pkg::SEL_NORMAL, 0, 0, 1);
    settle;
    u_far.pins(0, 0, sync_mode_pkg::SEL_FREE, 0, 0, 0);
    settle;
    lvl(sync_mode_pkg::MODE_FREE, 1'b0);
    u_far.pins(0, 0, sync_mode_pkg::SEL_HOLD, 0, 0, 0);
    u_far.loop(1'b1, f2);
    settle;
    lvl(sync_mode_pkg::MODE_HOLD, 1'b0);
    chk("hold_freq", {2'h0, f1}, {2'h0, holdover_freq_o});
    axr(sync_mode_pkg::OFS_STATUS, sync_mode_pkg::RESP_OKAY, 32'h45);
    pq.push_back(34'h1);
    u_far.pins(0, 0, sync_mode_pkg::SEL_NORMAL, 0, 0, 0);
    settle;
    lvl(sync_mode_pkg::MODE_NORMAL, 1'b0);
    u_far.pins(0, 0, sync_mode_pkg::SEL_HOLD, 0, 1, 0);
    settle;
    pq.push_back(34'h2);
    u_far.pins(0, 0, sync_mode_pkg::SEL_NORMAL, 0, 1, 0);
    settle;
    u_far.pins(0, 0, sync_mode_pkg::SEL_NORMAL, 1, 0, 0);
    settle;
    lvl(sync_mode_pkg::MODE_NORMAL, 1'b1);
    rstn_i <= 1'b0;
    u_far.pins(0, 0, sync_mode_pkg::SEL_NORMAL, 0, 0, 0);
    repeat (sync_mode_pkg::RST_MIN_CYC + 1) @(posedge clk_i);
    chk("hold_freq", 34'h0, {2'h0, holdover_freq_o});
    rstn_i <= 1'b1;
    settle;
    lvl(sync_mode_pkg::MODE_NORMAL, 1'b0);
    chk("hold_freq", {2'h0, f2}, {2'h0, holdover_freq_o});
    // loop unlocked: normal mode alone must not refresh the stored value
    u_far.loop(1'b0, f1);
    settle;
    chk("hold_freq", {2'h0, f2}, {2'h0, holdover_freq_o});
    axr(sync_mode_pkg::OFS_STATUS, sync_mode_pkg::RESP_OKAY, 32'h0);
    u_far.pins(0, 0, sync_mode_pkg::SEL_AUTO, 0, 0, 0);
    settle;
    u_far.pins(1, 0, sync_mode_pkg::SEL_AUTO, 0, 0, 0);
    settle;
    lvl(sync_mode_pkg::MODE_HOLD, 1'b0);
    pq.push_back(34'h1);
    u_far.pins(0, 0, sync_mode_pkg::SEL_AUTO, 0, 0, 0);
    settle;
    lvl(sync_mode_pkg::MODE_NORMAL, 1'b0);
    u_far.pins(1, 1, sync_mode_pkg::SEL_AUTO, 0, 0, 0);
    settle;
    u_far.pins(1, 1, sync_mode_pkg::SEL_AUTO, 0, 1, 0);
    settle;
    lvl(sync_mode_pkg::MODE_HOLD, 1'b0);
    pq.push_back(34'h1);
    u_far.pins(1, 0, sync_mode_pkg::SEL_AUTO, 0, 1, 0);
    settle;
    lvl(sync_mode_pkg::MODE_NORMAL, 1'b1);
    u_far.pins(1, 1, sync_mode_pkg::SEL_AUTO, 0, 1, 0);
    settle;
    lvl(sync_mode_pkg::MODE_HOLD, 1'b1);
    pq.push_back(34'h1);
    u_far.pins(0, 1, sync_mode_pkg::SEL_AUTO, 0, 1, 0);
    settle;
    lvl(sync_mode_pkg::MODE_NORMAL, 1'b0);
    wrap_up;
  end
endmodule
